// file: rtl/xps_core.sv
// Two-rank programming logic of a 16 x 8 crosspoint switch
`timescale 1ns/1ps
module xps_core
    import xps_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic chip_select_n,
    input wire logic serial_parallel_select,
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic [XPS_SLOT_W-1:0] parallel_data,
    input wire logic [XPS_ADDR_W-1:0] output_slot_address,
    input wire logic update_n,
    output logic serial_out,
    output logic [XPS_OUTPUTS-1:0] output_enable,
    output logic [XPS_OUTPUTS*XPS_SEL_W-1:0] input_select
);
    // Pins are asynchronous to clk; the first stage is read only by the second
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] d1;
        logic [4:0] d2;
        logic [2:0] a1;
        logic [2:0] a2;
        logic shift_clk_q;
        logic [XPS_CHAIN_W-1:0] first;
        logic [XPS_CHAIN_W-1:0] second;
        logic so;
        logic [XPS_OUTPUTS-1:0] en;
        logic [XPS_OUTPUTS*XPS_SEL_W-1:0] sel;
        logic [5:0] fill;
    } xps_state_t;

    xps_state_t state_reg;
    xps_state_t state_next;

    logic cs_n;
    logic mode;
    logic sclk;
    logic sdin;
    logic upd_n;
    logic fall;
    logic shift_now;
    logic [XPS_CHAIN_W-1:0] first_new;

    assign cs_n = state_reg.s2[0];
    assign mode = state_reg.s2[1];
    assign sclk = state_reg.s2[2];
    assign sdin = state_reg.s2[3];
    assign upd_n = state_reg.s2[4];
    assign fall = state_reg.shift_clk_q & ~sclk;
    assign shift_now = !cs_n && mode == XPS_MODE_SERIAL && fall;

    function automatic logic [XPS_CHAIN_W-1:0] put_slot(
        input logic [XPS_CHAIN_W-1:0] v,
        input logic [2:0] a,
        input logic [4:0] d
    );
        logic [XPS_CHAIN_W-1:0] r;
        r = v;
        r[a*XPS_SLOT_W +: XPS_SLOT_W] = d;
        return r;
    endfunction

    always_comb
    begin
        state_next = state_reg;
        state_next.s1 = {update_n, serial_in, shift_clock, serial_parallel_select, chip_select_n};
        state_next.s2 = state_reg.s1;
        state_next.d1 = parallel_data;
        state_next.d2 = state_reg.d1;
        state_next.a1 = output_slot_address;
        state_next.a2 = state_reg.a1;
        state_next.shift_clk_q = sclk;
        first_new = state_reg.first;
        if (!cs_n)
        begin
            if (mode == XPS_MODE_SERIAL && fall)
            begin
                first_new = {state_reg.first[XPS_CHAIN_W-2:0], sdin};
            end
            else if (mode == XPS_MODE_PARALLEL && !sclk)
            begin
                first_new = put_slot(state_reg.first, state_reg.a2, state_reg.d2);
            end
        end
        state_next.first = first_new;
        // Shift count only tells the checks when the unreset chain is known
        if (shift_now && state_reg.fill != 6'(XPS_CHAIN_W))
        begin
            state_next.fill = state_reg.fill + 6'h1;
        end
        state_next.so = first_new[XPS_CHAIN_W-1];
        if (!cs_n && !upd_n)
        begin
            state_next.second = state_reg.first;
        end
        for (int i = 0; i < XPS_OUTPUTS; i++)
        begin
            state_next.en[i] = state_next.second[i*XPS_SLOT_W + XPS_EN_POS];
            state_next.sel[i*XPS_SEL_W +: XPS_SEL_W] = state_next.en[i]
                ? state_next.second[i*XPS_SLOT_W + XPS_SEL_POS +: XPS_SEL_W] : 4'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_reg.second <= XPS_SECOND_RST;
            state_reg.en <= '0;
            state_reg.sel <= '0;
            state_reg.s1 <= state_next.s1;
            state_reg.s2 <= state_next.s2;
            state_reg.d1 <= state_next.d1;
            state_reg.d2 <= state_next.d2;
            state_reg.a1 <= state_next.a1;
            state_reg.a2 <= state_next.a2;
            state_reg.shift_clk_q <= state_next.shift_clk_q;
            state_reg.first <= state_next.first;
            state_reg.so <= state_next.so;
            state_reg.fill <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign serial_out = state_reg.so;
    assign output_enable = state_reg.en;
    assign input_select = state_reg.sel;

    // Assertions
    a_reset_clears: assert property (@(posedge clk)
        !rstn
        |=> output_enable == '0 && input_select == '0)
        else $error("Outputs not disabled after reset");
    a_freeze_first: assert property (@(posedge clk) disable iff (!rstn)
        cs_n && $past(cs_n)
        |=> $stable(state_reg.first))
        else $error("First rank changed while deselected");
    a_freeze_second: assert property (@(posedge clk) disable iff (!rstn)
        cs_n
        |=> $stable(state_reg.second))
        else $error("Second rank changed while deselected");
    a_shift_in: assert property (@(posedge clk) disable iff (!rstn)
        shift_now
        |=> state_reg.first[0] == $past(sdin))
        else $error("Serial bit not shifted in");
    // The first rank has no reset, so its far end is known only once filled
    a_far_end_out: assert property (@(posedge clk) disable iff (!rstn)
        shift_now && state_reg.fill >= 6'(XPS_CHAIN_W - 1)
        |=> serial_out == $past(state_reg.first[XPS_CHAIN_W-2]))
        else $error("Serial output not far end");
    a_slot_write: assert property (@(posedge clk) disable iff (!rstn)
        !cs_n && mode == XPS_MODE_PARALLEL && !sclk
        |=> state_reg.first[$past(state_reg.a2)*XPS_SLOT_W +: XPS_SLOT_W] == $past(state_reg.d2))
        else $error("Parallel slot not written");
    a_no_write_high: assert property (@(posedge clk) disable iff (!rstn)
        mode == XPS_MODE_PARALLEL && sclk
        |=> $stable(state_reg.first))
        else $error("First rank changed with clock high");
    a_latch_follow: assert property (@(posedge clk) disable iff (!rstn)
        !cs_n && !upd_n
        |=> state_reg.second == $past(state_reg.first))
        else $error("Second rank not transparent");
    a_second_hold: assert property (@(posedge clk) disable iff (!rstn)
        upd_n
        |=> $stable(state_reg.second))
        else $error("Second rank moved with strobe high");
    a_msb_parallel: assert property (@(posedge clk) disable iff (!rstn)
        !cs_n && mode == XPS_MODE_PARALLEL && !sclk && state_reg.a2 == 3'h7
        |=> serial_out == $past(state_reg.d2[XPS_EN_POS]))
        else $error("Serial output lost MSB in parallel mode");
    a_enable_map: assert property (@(posedge clk) disable iff (!rstn)
        output_enable[0] == state_reg.second[XPS_EN_POS])
        else $error("Enable does not follow slot bit");
    a_enable_top: assert property (@(posedge clk) disable iff (!rstn)
        output_enable[7] == state_reg.second[39])
        else $error("Top enable does not follow slot bit");
    a_sel_masked: assert property (@(posedge clk) disable iff (!rstn)
        !output_enable[1]
        |-> input_select[7:4] == 4'h0)
        else $error("Disabled output shows a select");
    a_sel_map: assert property (@(posedge clk) disable iff (!rstn)
        output_enable[7]
        |-> input_select[31:28] == state_reg.second[38:35])
        else $error("Select does not follow latch");
    a_sel_low: assert property (@(posedge clk) disable iff (!rstn)
        output_enable[0]
        |-> input_select[3:0] == state_reg.second[3:0])
        else $error("Low select does not follow latch");

    c_serial_shift: cover property (@(posedge clk) shift_now);
    c_parallel: cover property (@(posedge clk) !cs_n && mode == XPS_MODE_PARALLEL && !sclk);
    c_update: cover property (@(posedge clk) !cs_n && !upd_n && output_enable != '0);
    c_chain_full: cover property (@(posedge clk) state_reg.fill == 6'(XPS_CHAIN_W));
endmodule

// file: include/xps_pkg.sv
// Constants for the crosspoint switch programming logic
package xps_pkg;
    localparam int XPS_OUTPUTS = 8;
    localparam int XPS_SLOT_W = 5;
    localparam int XPS_SEL_W = 4;
    localparam int XPS_ADDR_W = 3;
    localparam int XPS_CHAIN_W = 40;
    localparam int XPS_EN_POS = 4;
    localparam int XPS_SEL_POS = 0;
    localparam logic [39:0] XPS_FIRST_RST = 40'h00_0000_0000;
    localparam logic [39:0] XPS_SECOND_RST = 40'h00_0000_0000;
    localparam logic XPS_MODE_SERIAL = 1'h0;
    localparam logic XPS_MODE_PARALLEL = 1'h1;
endpackage

// file: tb/xps_host.sv
// Host controller model driving the programming pins
`timescale 1ns/1ps
module xps_host
    import xps_pkg::*;
(
    input wire logic clk,
    output logic cs_n,
    output logic mode,
    output logic sck,
    output logic sdi,
    output logic [4:0] pd,
    output logic [2:0] pa,
    output logic upd_n
);
    initial
    begin
        {cs_n, mode, sck, sdi, pd, pa, upd_n} = 13'h0401;
    end
    task automatic set_cs_n(input logic v);
        cs_n = v;
    endtask
    task automatic set_upd_n(input logic v);
        upd_n = v;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic send(input logic [39:0] w);
        mode = XPS_MODE_SERIAL;
        for (int i = 39; i >= 0; i--)
        begin
            sdi = w[i];
            sck = 1'h1;
            tick(3);
            sck = 1'h0;
            tick(3);
        end
        sdi = ~sdi;
        sck = 1'h1;
        tick(3);
    endtask
    // Data held until the clock is back high
    task automatic load(input logic [2:0] a, input logic [4:0] d);
        mode = XPS_MODE_PARALLEL;
        pa = a;
        pd = d;
        tick(3);
        sck = 1'h0;
        tick(4);
        sck = 1'h1;
        tick(3);
        pd = ~d;
        tick(1);
    endtask
    task automatic strobe();
        upd_n = 1'h0;
        tick(6);
        upd_n = 1'h1;
        tick(3);
    endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the crosspoint programming logic
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error %0t %h %h", $time, a, b); end end
module testbench
    import xps_pkg::*;
;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic cs_n, mode, sck, sdi, upd_n, so;
    logic [4:0] pd;
    logic [2:0] pa;
    logic [7:0] oe;
    logic [31:0] isel;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [39:0] w = 40'hb5_3c_9e_71_a2;
    always #4 clk = ~clk;
    xps_host host (.clk(clk), .cs_n(cs_n), .mode(mode), .sck(sck), .sdi(sdi),
        .pd(pd), .pa(pa), .upd_n(upd_n));
    xps_core uut (.clk(clk), .rstn(rstn), .chip_select_n(cs_n),
        .serial_parallel_select(mode), .shift_clock(sck), .serial_in(sdi),
        .parallel_data(pd), .output_slot_address(pa), .update_n(upd_n),
        .serial_out(so), .output_enable(oe), .input_select(isel));
    task automatic check_out();
        logic [7:0] en;
        logic [31:0] sel;
        for (int i = 0; i < 8; i++)
        begin
            en[i] = w[5*i+4];
            sel[4*i+:4] = en[i] ? w[5*i+:4] : 4'h0;
        end
        `CHK(oe, en)
        `CHK(isel, sel)
        `CHK(so, w[39])
    endtask
    task automatic t_serial();
        host.send(w);
        host.strobe();
        check_out();
    endtask
    task automatic t_parallel();
        host.load(3'h2, 5'h1c);
        w[10+:5] = 5'h1c;
        host.set_upd_n(1'h0);
        host.load(3'h7, 5'h0b);
        w[35+:5] = 5'h0b;
        check_out();
        host.set_upd_n(1'h1);
        `CHK(so, 1'h0)
    endtask
    task automatic t_chipsel();
        host.set_cs_n(1'h1);
        host.tick(3);
        host.send(~w);
        host.load(3'h0, 5'h1f);
        host.strobe();
        check_out();
        host.set_cs_n(1'h0);
        host.tick(3);
    endtask
    task automatic t_reset();
        rstn = 1'h0;
        host.tick(2);
        `CHK({oe, isel}, 40'h0)
        rstn = 1'h1;
        host.strobe();
        check_out();
    endtask
    task automatic report_and_stop();
        $display("Mismatches %0d of %0d compares", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        host.tick(2);
        rstn = 1'h1;
        t_serial();
        t_parallel();
        t_chipsel();
        t_reset();
        report_and_stop();
    end
    // Run needs about 560 cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
